// ===== dv/reg_host_model.sv
`timescale 1ns/100ps
module reg_host_model (
  input  wire logic        clock_in,
  input  wire logic  [7:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  output logic      [11:0] reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic       [7:0] reg_wdata_out
);
  // Idle bus at start
  initial begin
    {reg_addr_out, reg_wr_out, reg_rd_out, reg_wdata_out} = '0;
  end

  // One write strobe, bus scrambled when released
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge clock_in);
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  // One read strobe, data only taken with valid
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge clock_in);
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
    d = reg_rvalid_in === 1'b1 ? reg_rdata_in : 8'hXX;
  endtask : rd
endmodule : reg_host_model

// ===== dv/serdes_rx_phy_config_props.sv
`timescale 1ns/100ps
`include "serdes_rx_phy_consts.svh"
module serdes_rx_phy_checker #(
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic  [7:0] reg_wdata_in,
  input wire logic  [7:0] reg_rdata_out,
  input wire logic        pll_lock_in,
  input wire logic        pll_cal_ok_in,
  input wire logic        pll_band_high_in,
  input wire logic        if_powerdown_out,
  input wire logic  [7:0] lane_powerdown_out,
  input wire logic  [1:0] term_cal_busy_out,
  input wire logic        pll_recal_out,
  input wire logic        cdr_half_rate_enable_out,
  input wire logic  [1:0] cdr_rate_divider_out,
  input wire logic  [7:0] cdr_reset_lane_out,
  input wire logic  [5:0] pclk_lane_ratio_out
);
  // ****************************************
  // Write and read decodes and busy length counter
  // ****************************************
  logic [7:0] busy_run;
  wire        go_a  = reg_wr_in && reg_addr_in == `CAL_A_ADDR;
  wire        go_b  = reg_wr_in && reg_addr_in == `CAL_B_ADDR;
  wire        recal = reg_wr_in && reg_addr_in == `PLL_CTRL_ADDR;
  wire        stat  = reg_rd_in && reg_addr_in == `PLL_STAT_ADDR;

  // Counts consecutive busy cycles of group A
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) busy_run <= 8'h00;
    else busy_run <= term_cal_busy_out[0] ? busy_run + 8'h01 : 8'h00;
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  AST_PD_ALL: assert property (
    if_powerdown_out |-> lane_powerdown_out == 8'hFF)
    else $error("lane up while interface down");
  AST_CDR_PD: assert property (
    (lane_powerdown_out & ~cdr_reset_lane_out) == 8'h00)
    else $error("powered-down lane not in recovery reset");
  AST_WR_PD: assert property (
    reg_wr_in && reg_addr_in == `LANE_PD_ADDR && !if_powerdown_out
    |=> lane_powerdown_out == $past(reg_wdata_in))
    else $error("lane mask not applied");
  AST_CAL_A: assert property (
    $rose(term_cal_busy_out[0]) |-> $past(go_a) && $past(reg_wdata_in[0]))
    else $error("group A calibration without start write");
  AST_CAL_B: assert property (
    $rose(term_cal_busy_out[1]) |-> $past(go_b) && $past(reg_wdata_in[0]))
    else $error("group B calibration without start write");
  AST_CAL_LEN: assert property (
    $fell(term_cal_busy_out[0]) |-> busy_run >= CAL_CYCLES - 1)
    else $error("calibration ended early");
  AST_RECAL: assert property (
    pll_recal_out |-> ($past(recal) || $past(recal, 2)) ##1 !pll_recal_out)
    else $error("recalibration pulse wrong");
  AST_STAT_LIVE: assert property (
    stat |=> reg_rdata_out[0] == $past(pll_lock_in)
    && reg_rdata_out[3] == $past(pll_cal_ok_in))
    else $error("status lock or calibration bit wrong");
  AST_STICKY: assert property (
    pll_band_high_in ##1 !recal ##1 stat |=> reg_rdata_out[5])
    else $error("upper band flag not held");
  AST_CDR_MODE: assert property (
    reg_wr_in && reg_addr_in == `CDR_MODE_ADDR
    |=> cdr_half_rate_enable_out == $past(reg_wdata_in[5])
    && cdr_rate_divider_out == $past(reg_wdata_in[2:1]))
    else $error("recovery mode fields wrong");
  AST_PCLK: assert property (
    pclk_lane_ratio_out == 6'h28)
    else $error("processing clock ratio wrong");
endmodule : serdes_rx_phy_checker

bind serdes_rx_phy_config serdes_rx_phy_checker #(
  .CAL_CYCLES(CAL_CYCLES)
) u_checker (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .pll_lock_in(pll_lock_in), .pll_cal_ok_in(pll_cal_ok_in),
  .pll_band_high_in(pll_band_high_in),
  .if_powerdown_out(if_powerdown_out),
  .lane_powerdown_out(lane_powerdown_out),
  .term_cal_busy_out(term_cal_busy_out), .pll_recal_out(pll_recal_out),
  .cdr_half_rate_enable_out(cdr_half_rate_enable_out),
  .cdr_rate_divider_out(cdr_rate_divider_out),
  .cdr_reset_lane_out(cdr_reset_lane_out),
  .pclk_lane_ratio_out(pclk_lane_ratio_out)
);

// ===== dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [11:0] a;
    logic  [7:0] d;
    logic  [7:0] e;
  } row_type;

  logic        clock_in, rst_b_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic [11:0] reg_addr_in;
  logic  [7:0] reg_wdata_in, reg_rdata_out, lane_pd, cdr_rst, rv;
  logic  [3:0] meas_a, meas_b;
  logic        lock, cal_ok, band_lo, band_hi, if_pd, pll_en, recal, half;
  logic  [1:0] busy, ref_div, cdr_div;
  logic [31:0] codes;
  logic  [5:0] ratio;
  logic  [3:0] ofs [8];
  logic [15:0] ov = 16'h7FB3;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_recal = 0;
  row_type     rows [13] = '{
    '{12'h201, 8'hA5, 8'hA5}, '{12'h289, 8'h02, 8'h02},
    '{12'h230, 8'h04, 8'h04}, '{12'h289, 8'h01, 8'h01},
    '{12'h230, 8'h02, 8'h02}, '{12'h230, 8'h00, 8'h00},
    '{12'h289, 8'h00, 8'h00}, '{12'h230, 8'h20, 8'h20},
    '{12'h280, 8'h01, 8'h01}, '{12'h206, 8'h01, 8'h01},
    '{12'h2FF, 8'h55, 8'h00}, '{12'h281, 8'hFF, 8'h09},
    '{12'h2B3, 8'hFF, 8'h00}};

  serdes_rx_phy_config #(.CAL_CYCLES(4)) u_dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .term_meas_a_in(meas_a),
    .term_meas_b_in(meas_b), .pll_lock_in(lock), .pll_cal_ok_in(cal_ok),
    .pll_band_low_in(band_lo), .pll_band_high_in(band_hi),
    .if_powerdown_out(if_pd), .lane_powerdown_out(lane_pd),
    .term_cal_busy_out(busy), .term_code_lane_out(codes),
    .pll_enable_out(pll_en), .pll_recal_out(recal),
    .lane_pll_ref_divider_out(ref_div), .cdr_half_rate_enable_out(half),
    .cdr_rate_divider_out(cdr_div), .cdr_reset_lane_out(cdr_rst),
    .pclk_lane_ratio_out(ratio));

  reg_host_model u_host (
    .clock_in(clock_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_wdata_out(reg_wdata_in));

  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  initial begin
    #500000;
    bad_count++;
    stop_test();
  end

  // Counts recalibration pulses
  always @(negedge clock_in) if (recal === 1'b1) n_recal++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Sign-magnitude offset, clamped to the code range
  function automatic logic [3:0] adj(input logic [3:0] b, input logic [3:0] o);
    int v;
    v = o[3] ? int'(b) - int'(o[2:0]) : int'(b) + int'(o[2:0]);
    return v < 0 ? 4'h0 : (v > 15 ? 4'hF : v[3:0]);
  endfunction : adj

  // Lanes 0, 1, 6, 7 take base a, the rest base b
  task automatic lanes(input logic [3:0] a, input logic [3:0] b);
    logic [31:0] e;
    for (int g = 0; g < 8; g++) begin
      e[4*g +: 4] = adj((g < 2 || g > 5) ? a : b, ofs[g]);
    end
    check(codes, e);
  endtask : lanes

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_b_in, lock, cal_ok, band_lo, band_hi} = 5'b01100;
    meas_a = 4'h5;
    meas_b = 4'h9;
    ofs = '{default: 4'h0};
    repeat (4) @(negedge clock_in);
    rst_b_in = 1'b1;
    check({if_pd, lane_pd, cdr_rst, pll_en, busy, ratio}, 26'h3FFFE28);
    u_host.rd(12'h200, rv);
    check(rv, 8'h01);
    u_host.wr(12'h200, 8'h00);
    check({if_pd, lane_pd}, 9'h000);
    for (int i = 0; i < 13; i++) begin
      u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a, rv);
      check(rv, rows[i].e);
    end
    check({lane_pd, cdr_rst, half, cdr_div, ref_div, pll_en}, 22'h297FE1);
    u_host.wr(12'h206, 8'h00);
    check(cdr_rst, 8'hA5);
    u_host.wr(12'h201, 8'h00);
    check({lane_pd, cdr_rst}, 16'h0000);
    u_host.wr(12'h2A7, 8'h01);
    check(busy, 2'b01);
    u_host.wr(12'h2AE, 8'h01);
    check(busy[1], 1'b1);
    for (int i = 0; i < 20 && busy !== 2'b00; i++) @(negedge clock_in);
    check(busy, 2'b00);
    repeat (2) @(negedge clock_in);
    u_host.rd(12'h2AC, rv);
    check(rv[3:0], 4'h5);
    u_host.rd(12'h2B3, rv);
    check(rv[3:0], 4'h9);
    lanes(4'h5, 4'h9);
    u_host.wr(12'h2A7, 8'h01);
    check(busy, 2'b00);
    for (int i = 0; i < 4; i++) begin
      ofs[i] = ov[4*i +: 4];
      u_host.wr(12'h2BB + 12'(i), {4'h0, ofs[i]});
    end
    repeat (2) @(negedge clock_in);
    lanes(4'h5, 4'h9);
    u_host.wr(12'h2A8, 8'h16);
    repeat (2) @(negedge clock_in);
    lanes(4'h3, 4'h9);
    for (int k = 0; k < 2; k++) begin
      @(negedge clock_in);
      {band_lo, band_hi} = k ? 2'b10 : 2'b01;
      @(negedge clock_in);
      {band_lo, band_hi} = 2'b00;
      u_host.rd(12'h281, rv);
      check(rv, k ? 8'h19 : 8'h29);
      u_host.wr(12'h280, 8'h01);
      u_host.wr(12'h280, 8'h05);
      repeat (2) @(negedge clock_in);
      u_host.rd(12'h281, rv);
      check(rv, 8'h09);
    end
    check(n_recal, 2);
    @(negedge clock_in);
    rst_b_in = 1'b0;
    @(negedge clock_in);
    check({if_pd, lane_pd, pll_en}, 10'h3FE);
    rst_b_in = 1'b1;
    stop_test();
  end
endmodule : tb_top

// ===== hdl/lane_term_adjust.sv
`timescale 1ns/100ps
`include "serdes_rx_phy_consts.svh"
module lane_term_adjust (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] base_in,
  input  wire logic [3:0] offset_in,
  output logic      [3:0] code_out
);

  wire       negative;
  wire [4:0] magnitude;
  wire [4:0] sum;
  wire [4:0] next_code;

  // Sign-magnitude offset with clamping to the code range
  assign negative  = offset_in[`OFS_SIGN_BIT];
  assign magnitude = {2'b00, offset_in[2:0]};
  assign sum       = {1'b0, base_in} + magnitude;
  assign next_code = negative
                   ? (({1'b0, base_in} < magnitude) ? 5'h00
                      : {1'b0, base_in} - magnitude)
                   : (sum[4] ? 5'h0F : sum);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      code_out <= 4'h0;
    end else begin
      code_out <= next_code[3:0];
    end
  end

endmodule : lane_term_adjust

// ===== hdl/serdes_rx_phy_config.sv
`timescale 1ns/100ps
`include "serdes_rx_phy_consts.svh"
module serdes_rx_phy_config #(
  parameter int LANES      = 8,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic       [11:0] reg_addr_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic        [7:0] reg_wdata_in,
  output logic             [7:0] reg_rdata_out,
  output logic                   reg_rvalid_out,
  input  wire logic        [3:0] term_meas_a_in,
  input  wire logic        [3:0] term_meas_b_in,
  input  wire logic              pll_lock_in,
  input  wire logic              pll_cal_ok_in,
  input  wire logic              pll_band_low_in,
  input  wire logic              pll_band_high_in,
  output logic                   if_powerdown_out,
  output logic       [LANES-1:0] lane_powerdown_out,
  output logic             [1:0] term_cal_busy_out,
  output logic     [4*LANES-1:0] term_code_lane_out,
  output logic                   pll_enable_out,
  output logic                   pll_recal_out,
  output logic             [1:0] lane_pll_ref_divider_out,
  output logic                   cdr_half_rate_enable_out,
  output logic             [1:0] cdr_rate_divider_out,
  output logic       [LANES-1:0] cdr_reset_lane_out,
  output logic             [5:0] pclk_lane_ratio_out
);

  // ***********************************************************
  // Register storage
  // ***********************************************************

  logic [7:0] serial_if_power_ctrl;
  logic [7:0] lane_powerdown_mask;
  logic [7:0] cdr_reset_ctrl;
  logic [7:0] cdr_mode_cfg;
  logic [7:0] lane_pll_ctrl;
  logic [7:0] lane_pll_divider;
  logic [7:0] term_cal_ctrl_group_a;
  logic [7:0] term_override_group_a;
  logic [7:0] term_cal_ctrl_group_b;
  logic [7:0] term_override_group_b;
  logic [7:0] term_offset [LANES];
  logic       band_low_seen;
  logic       band_high_seen;

  // ***********************************************************
  // Address decode
  // ***********************************************************

  wire        hit_if_pwr;
  wire        hit_lane_pd;
  wire        hit_cdr_rst;
  wire        hit_cdr_mode;
  wire        hit_pll_ctrl;
  wire        hit_pll_stat;
  wire        hit_pll_div;
  wire        hit_cal_a;
  wire        hit_ovr_a;
  wire        hit_code_a;
  wire        hit_cal_b;
  wire        hit_ovr_b;
  wire        hit_code_b;
  wire        hit_offset;
  wire [11:0] offset_delta;
  wire  [2:0] offset_index;

  // One hit line per register
  assign hit_if_pwr   = (reg_addr_in == `IF_PWR_ADDR);
  assign hit_lane_pd  = (reg_addr_in == `LANE_PD_ADDR);
  assign hit_cdr_rst  = (reg_addr_in == `CDR_RST_ADDR);
  assign hit_cdr_mode = (reg_addr_in == `CDR_MODE_ADDR);
  assign hit_pll_ctrl = (reg_addr_in == `PLL_CTRL_ADDR);
  assign hit_pll_stat = (reg_addr_in == `PLL_STAT_ADDR);
  assign hit_pll_div  = (reg_addr_in == `PLL_DIV_ADDR);
  assign hit_cal_a    = (reg_addr_in == `CAL_A_ADDR);
  assign hit_ovr_a    = (reg_addr_in == `OVR_A_ADDR);
  assign hit_code_a   = (reg_addr_in == `CODE_A_ADDR);
  assign hit_cal_b    = (reg_addr_in == `CAL_B_ADDR);
  assign hit_ovr_b    = (reg_addr_in == `OVR_B_ADDR);
  assign hit_code_b   = (reg_addr_in == `CODE_B_ADDR);

  // Eight consecutive offset registers, one per lane
  assign hit_offset   = (reg_addr_in >= `OFS_FIRST_ADDR)
                     && (reg_addr_in <= `OFS_LAST_ADDR);
  assign offset_delta = reg_addr_in - `OFS_FIRST_ADDR;
  assign offset_index = offset_delta[2:0];

  // ***********************************************************
  // Write strobes and edge events
  // ***********************************************************

  wire wr_cal_a;
  wire wr_cal_b;
  wire wr_pll_ctrl;
  wire cal_start_a;
  wire cal_start_b;
  wire recal_start;

  assign wr_cal_a    = reg_wr_in && hit_cal_a;
  assign wr_cal_b    = reg_wr_in && hit_cal_b;
  assign wr_pll_ctrl = reg_wr_in && hit_pll_ctrl;

  // Low-to-high of the go bit starts each group's calibration
  assign cal_start_a = wr_cal_a
                    && reg_wdata_in[`CAL_GO_BIT]
                    && !term_cal_ctrl_group_a[`CAL_GO_BIT];
  assign cal_start_b = wr_cal_b
                    && reg_wdata_in[`CAL_GO_BIT]
                    && !term_cal_ctrl_group_b[`CAL_GO_BIT];

  // Rising edge of the recalibration bit
  assign recal_start = wr_pll_ctrl
                    && reg_wdata_in[`PLL_RECAL_BIT]
                    && !lane_pll_ctrl[`PLL_RECAL_BIT];

  // ***********************************************************
  // Control registers
  // ***********************************************************

  // Power, clock recovery and PLL control
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_if_power_ctrl <= `IF_PWR_RST;
      lane_powerdown_mask  <= `LANE_PD_RST;
      cdr_reset_ctrl       <= `CTRL_RST;
      cdr_mode_cfg         <= `CTRL_RST;
      lane_pll_ctrl        <= `CTRL_RST;
      lane_pll_divider     <= `CTRL_RST;
    end else if (reg_wr_in) begin
      if (hit_if_pwr) begin
        serial_if_power_ctrl <= reg_wdata_in;
      end
      if (hit_lane_pd) begin
        lane_powerdown_mask <= reg_wdata_in;
      end
      if (hit_cdr_rst) begin
        cdr_reset_ctrl <= reg_wdata_in;
      end
      if (hit_cdr_mode) begin
        cdr_mode_cfg <= reg_wdata_in;
      end
      if (hit_pll_ctrl) begin
        lane_pll_ctrl <= reg_wdata_in;
      end
      if (hit_pll_div) begin
        lane_pll_divider <= reg_wdata_in;
      end
    end
  end

  // Termination calibration and override control
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      term_cal_ctrl_group_a <= `CTRL_RST;
      term_override_group_a <= `CTRL_RST;
      term_cal_ctrl_group_b <= `CTRL_RST;
      term_override_group_b <= `CTRL_RST;
    end else if (reg_wr_in) begin
      if (hit_cal_a) begin
        term_cal_ctrl_group_a <= reg_wdata_in;
      end
      if (hit_ovr_a) begin
        term_override_group_a <= reg_wdata_in;
      end
      if (hit_cal_b) begin
        term_cal_ctrl_group_b <= reg_wdata_in;
      end
      if (hit_ovr_b) begin
        term_override_group_b <= reg_wdata_in;
      end
    end
  end

  // Per-lane termination offsets
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < LANES; i++) begin
        term_offset[i] <= `CTRL_RST;
      end
    end else if (reg_wr_in && hit_offset) begin
      term_offset[offset_index] <= reg_wdata_in;
    end
  end

  // ***********************************************************
  // PLL status
  // ***********************************************************

  wire next_band_low;
  wire next_band_high;
  wire [7:0] pll_status;

  // Band-limit flags hold until a recalibration; a new hit wins
  assign next_band_low  = pll_band_low_in
                       || (band_low_seen && !recal_start);
  assign next_band_high = pll_band_high_in
                       || (band_high_seen && !recal_start);

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      band_low_seen  <= 1'b0;
      band_high_seen <= 1'b0;
    end else begin
      band_low_seen  <= next_band_low;
      band_high_seen <= next_band_high;
    end
  end

  // Lock in bit 0, calibrated in bit 3, band limits in bits 4 and 5
  assign pll_status = {2'b00, band_high_seen, band_low_seen,
                       pll_cal_ok_in, 2'b00, pll_lock_in};

  // ***********************************************************
  // Termination calibration engines
  // ***********************************************************

  wire [3:0] cal_code_a;
  wire [3:0] cal_code_b;
  wire       cal_busy_a;
  wire       cal_busy_b;

  // Group A: lanes 0, 1, 6 and 7
  term_cal_engine #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal_a (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .start_in     (cal_start_a),
    .meas_code_in (term_meas_a_in),
    .busy_out     (cal_busy_a),
    .code_out     (cal_code_a)
  );

  // Group B: lanes 2, 3, 4 and 5
  term_cal_engine #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal_b (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .start_in     (cal_start_b),
    .meas_code_in (term_meas_b_in),
    .busy_out     (cal_busy_b),
    .code_out     (cal_code_b)
  );

  assign term_cal_busy_out = {cal_busy_b, cal_busy_a};

  // ***********************************************************
  // Termination code per lane
  // ***********************************************************

  wire [3:0] group_code_a;
  wire [3:0] group_code_b;
  wire [LANES-1:0] in_group_a;

  // Override replaces the calibrated code when bit 4 is set
  assign group_code_a = term_override_group_a[`OVR_EN_BIT]
                      ? {1'b0, term_override_group_a[3:1]}
                      : cal_code_a;
  assign group_code_b = term_override_group_b[`OVR_EN_BIT]
                      ? {1'b0, term_override_group_b[3:1]}
                      : cal_code_b;

  assign in_group_a = LANES'(`GROUP_A_LANES);

  // Each lane takes its group's code plus its own offset
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    wire [3:0] lane_base;

    assign lane_base = in_group_a[g] ? group_code_a : group_code_b;

    lane_term_adjust u_adjust (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .base_in   (lane_base),
      .offset_in (term_offset[g][3:0]),
      .code_out  (term_code_lane_out[4*g +: 4])
    );
  end

  // ***********************************************************
  // Power, PLL and clock recovery outputs
  // ***********************************************************

  wire [LANES-1:0] lane_off;

  // Whole interface down forces every lane down
  assign if_powerdown_out   = serial_if_power_ctrl[`IF_PD_BIT];
  assign lane_off           = lane_powerdown_mask[LANES-1:0]
                            | {LANES{if_powerdown_out}};
  assign lane_powerdown_out = lane_off;

  // PLL enable and reference divider
  assign pll_enable_out           = lane_pll_ctrl[`PLL_EN_BIT];
  assign lane_pll_ref_divider_out = lane_pll_divider[1:0];

  // Clock recovery mode
  assign cdr_half_rate_enable_out = cdr_mode_cfg[`CDR_HALF_BIT];
  assign cdr_rate_divider_out     = cdr_mode_cfg[2:1];

  // Recovery reset per lane: shared reset or own power-down
  assign cdr_reset_lane_out = lane_off
                            | {LANES{cdr_reset_ctrl[`CDR_RST_BIT]}};

  // Lane bits per processing clock: ten bits a byte, four bytes
  assign pclk_lane_ratio_out = 6'(`BITS_PER_BYTE * `BYTES_PER_PCLK);

  // One-cycle recalibration request to the PLL
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pll_recal_out <= 1'b0;
    end else begin
      pll_recal_out <= recal_start;
    end
  end

  // ***********************************************************
  // Read path
  // ***********************************************************

  wire [7:0] read_mux;
  wire [7:0] offset_read;

  assign offset_read = hit_offset ? term_offset[offset_index] : 8'h00;

  // Unmapped addresses read as zero
  assign read_mux = ({8{hit_if_pwr}}   & serial_if_power_ctrl)
                  | ({8{hit_lane_pd}}  & lane_powerdown_mask)
                  | ({8{hit_cdr_rst}}  & cdr_reset_ctrl)
                  | ({8{hit_cdr_mode}} & cdr_mode_cfg)
                  | ({8{hit_pll_ctrl}} & lane_pll_ctrl)
                  | ({8{hit_pll_stat}} & pll_status)
                  | ({8{hit_pll_div}}  & lane_pll_divider)
                  | ({8{hit_cal_a}}    & term_cal_ctrl_group_a)
                  | ({8{hit_ovr_a}}    & term_override_group_a)
                  | ({8{hit_code_a}}   & {4'h0, cal_code_a})
                  | ({8{hit_cal_b}}    & term_cal_ctrl_group_b)
                  | ({8{hit_ovr_b}}    & term_override_group_b)
                  | ({8{hit_code_b}}   & {4'h0, cal_code_b})
                  | offset_read;

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= read_mux;
      end
    end
  end

endmodule : serdes_rx_phy_config

// ===== hdl/serdes_rx_phy_consts.svh
`ifndef SERDES_RX_PHY_CONSTS_SVH
`define SERDES_RX_PHY_CONSTS_SVH

// Register offsets
`define IF_PWR_ADDR    12'h200
`define LANE_PD_ADDR   12'h201
`define CDR_RST_ADDR   12'h206
`define CDR_MODE_ADDR  12'h230
`define PLL_CTRL_ADDR  12'h280
`define PLL_STAT_ADDR  12'h281
`define PLL_DIV_ADDR   12'h289
`define CAL_A_ADDR     12'h2A7
`define OVR_A_ADDR     12'h2A8
`define CODE_A_ADDR    12'h2AC
`define CAL_B_ADDR     12'h2AE
`define OVR_B_ADDR     12'h2AF
`define CODE_B_ADDR    12'h2B3
`define OFS_FIRST_ADDR 12'h2BB
`define OFS_LAST_ADDR  12'h2C2

// Field positions
`define IF_PD_BIT      0
`define CAL_GO_BIT     0
`define OVR_EN_BIT     4
`define PLL_EN_BIT     0
`define PLL_RECAL_BIT  2
`define CDR_RST_BIT    0
`define CDR_HALF_BIT   5
`define OFS_SIGN_BIT   3

// Reset values
`define IF_PWR_RST     8'h01
`define LANE_PD_RST    8'h00
`define CTRL_RST       8'h00

// Lanes of calibration group A
`define GROUP_A_LANES  8'hC3

// Clock relationships
`define BITS_PER_BYTE  6'h0A
`define BYTES_PER_PCLK 6'h04

// Calibration run length in clock cycles
`define CAL_CYCLES     64

`endif

// ===== hdl/serdes_rx_phy_pkg.sv
package serdes_rx_phy_pkg;

  // Calibration engine states
  typedef enum logic {
    CAL_IDLE,
    CAL_RUN
  } cal_state_type;

endpackage : serdes_rx_phy_pkg

// ===== hdl/term_cal_engine.sv
`timescale 1ns/100ps
module term_cal_engine #(
  parameter int CAL_CYCLES = 64
) (
  input  wire logic       clock_in,
  input  wire logic       rst_b_in,
  input  wire logic       start_in,
  input  wire logic [3:0] meas_code_in,
  output logic            busy_out,
  output logic      [3:0] code_out
);

  serdes_rx_phy_pkg::cal_state_type state;
  logic [15:0]                      count;
  wire                              last_cycle;

  assign last_cycle = (count == 16'(CAL_CYCLES - 1));
  assign busy_out   = (state == serdes_rx_phy_pkg::CAL_RUN);

  // Run for a fixed time, then latch the measured code
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state    <= serdes_rx_phy_pkg::CAL_IDLE;
      count    <= 16'h0000;
      code_out <= 4'h0;
    end else if (start_in) begin
      state <= serdes_rx_phy_pkg::CAL_RUN;
      count <= 16'h0000;
    end else begin
      unique case (state)
        serdes_rx_phy_pkg::CAL_IDLE: begin
          count <= 16'h0000;
        end
        serdes_rx_phy_pkg::CAL_RUN: begin
          count <= count + 16'h0001;
          if (last_cycle) begin
            state    <= serdes_rx_phy_pkg::CAL_IDLE;
            code_out <= meas_code_in;
          end
        end
      endcase
    end
  end

endmodule : term_cal_engine
